// ### hdl/dps_pkg.sv
// package: address, field positions and reset values for the dual pointer block
package dps_pkg;
    localparam logic [7:0] DPS_AUX_ADDR = 8'ha2;
    localparam int DPS_SEL_BIT = 0;
    localparam int DPS_ZERO_BIT = 2;
    localparam int DPS_FLAG_BIT = 3;
    localparam int DPS_BOOT_BIT = 5;
    localparam logic [15:0] DPS_BOOT_LO = 16'hf800;
    localparam logic [15:0] DPS_BOOT_HI = 16'hffff;
    localparam logic [15:0] DPS_PTR_RST = 16'h0000;
    localparam logic [15:0] DPS_PTR_ONE = 16'h0001;
    localparam logic [7:0] DPS_BYTE_ZERO = 8'h00;
    localparam logic [7:0] DPS_BYTE_ONE = 8'h01;
    // pointer operation codes from the core
    typedef enum logic [1:0] {
        DPS_OP_NONE,
        DPS_OP_LOAD,
        DPS_OP_INC
    } dps_op_e;
endpackage

// ### hdl/dps_ptr_bank.sv
// module: the two 16-bit data pointers, only the selected one changes
`timescale 1ns/1ns
module dps_ptr_bank
    import dps_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // control
    dps_ptr_if.bank pb
);
    logic [15:0] ptr0_r;
    logic [15:0] ptr0_nxt;
    logic [15:0] ptr1_r;
    logic [15:0] ptr1_nxt;

    // next pointer value for one register
    function automatic logic [15:0] ptrNext(input logic [15:0] cur, input dps_op_e op, input logic [15:0] ld);
        case (op)
            DPS_OP_LOAD: ptrNext = ld;
            DPS_OP_INC: ptrNext = cur + DPS_PTR_ONE;
            default: ptrNext = cur;
        endcase
    endfunction

    always_comb begin
        ptr0_nxt = pb.sel ? ptr0_r : ptrNext(ptr0_r, pb.op, pb.loadVal);
        ptr1_nxt = pb.sel ? ptrNext(ptr1_r, pb.op, pb.loadVal) : ptr1_r;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ptr0_r <= DPS_PTR_RST;
            ptr1_r <= DPS_PTR_RST;
        end else if (clkEn) begin
            ptr0_r <= ptr0_nxt;
            ptr1_r <= ptr1_nxt;
        end
    end

    assign pb.ptrZero = ptr0_r;
    assign pb.ptrOne = ptr1_r;

    // pointer one holds while unselected
    chk_unsel_holds: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && !pb.sel |=> $stable(ptr1_r)) else $error("pointer one changed while unselected");
    chk_inc_adds_one: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && !pb.sel && pb.op == DPS_OP_INC |=> ptr0_r == $past(ptr0_r) + DPS_PTR_ONE)
        else $error("pointer zero increment wrong");
    chk_load_one: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && pb.sel && pb.op == DPS_OP_LOAD |=> ptr1_r == $past(pb.loadVal))
        else $error("pointer one load wrong");
endmodule // dps_ptr_bank

// ### hdl/dps_ptr_if.sv
// interface: pointer-bank control between the top and the pointer bank
`timescale 1ns/1ns
interface dps_ptr_if;
    import dps_pkg::*;
    logic sel;
    dps_op_e op;
    logic [15:0] loadVal;
    logic [15:0] ptrZero;
    logic [15:0] ptrOne;
    modport ctrl (output sel, output op, output loadVal, input ptrZero, input ptrOne);
    modport bank (input sel, input op, input loadVal, output ptrZero, output ptrOne);
endinterface

// ### hdl/dual_pointer_select.sv
// module: dual data pointer with auxiliary pointer-select control register
// Notes on behaviour
// - Two separate 16-bit pointers, each addresses external data memory.
// - Load, increment and use act on the selected pointer; the other holds.
// - Selector bit 0 low picks pointer zero, high picks pointer one.
// - Auxiliary register sits at special-function address a2h.
// - Bit 5 set maps boot memory over f800h to ffffh; clear disables it.
// - Bit 3 is a plain software flag with no hardware effect.
// - Bit 2 reads zero, ignores writes; bit 1 reads zero, so increment only toggles selector.
// - Incrementing the register flips the selector relative to its state.
`timescale 1ns/1ns
module dual_pointer_select
    import dps_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // boot configuration strap, active-low jump bit
    input wire logic bootJumpCfg_n,
    // special-function register port
    input wire logic sfrWr,
    input wire logic sfrRd,
    input wire logic sfrInc,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    output logic sfrHit,
    // pointer operations
    input wire logic ptrLoad,
    input wire logic ptrInc,
    input wire logic [15:0] ptrLoadVal,
    output logic [15:0] dataPointer,
    // status
    output logic pointerSelector,
    output logic bootMapEnable,
    output logic generalUserFlag,
    output logic bootWindowHit
);
    dps_ptr_if pif ();

    logic sel_r;
    logic sel_nxt;
    logic flag_r;
    logic flag_nxt;
    logic boot_r;
    logic boot_nxt;
    logic bootLoad_r;
    logic bootLoad_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic addrHit;
    logic [7:0] regView;
    logic [7:0] regPlus;

    // register image; unused bits read zero, bit 2 tied low
    function automatic logic [7:0] auxImage(input logic s, input logic f, input logic b);
        auxImage = DPS_BYTE_ZERO;
        auxImage[DPS_SEL_BIT] = s;
        auxImage[DPS_FLAG_BIT] = f;
        auxImage[DPS_BOOT_BIT] = b;
    endfunction

    assign addrHit = sfrAddr == DPS_AUX_ADDR;
    assign regView = auxImage(sel_r, flag_r, boot_r);
    // zero bit 1 stops carry into the flag
    assign regPlus = regView + DPS_BYTE_ONE;

    // register next-state; write has priority over increment
    always_comb begin
        sel_nxt = sel_r;
        flag_nxt = flag_r;
        boot_nxt = boot_r;
        bootLoad_nxt = 1'b0;
        rdata_nxt = rdata_r;
        if (bootLoad_r) begin
            // boot enable caught after reset release
            boot_nxt = ~bootJumpCfg_n;
        end
        if (addrHit && sfrWr) begin
            sel_nxt = sfrWdata[DPS_SEL_BIT];
            flag_nxt = sfrWdata[DPS_FLAG_BIT];
            boot_nxt = sfrWdata[DPS_BOOT_BIT];
        end else if (addrHit && sfrInc) begin
            sel_nxt = regPlus[DPS_SEL_BIT];
            flag_nxt = regPlus[DPS_FLAG_BIT];
            boot_nxt = regPlus[DPS_BOOT_BIT];
        end
        if (addrHit && sfrRd) begin
            rdata_nxt = regView;
        end
    end

    // control register state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sel_r <= 1'b0;
            flag_r <= 1'b0;
            boot_r <= 1'b0;
            bootLoad_r <= 1'b1;
            rdata_r <= DPS_BYTE_ZERO;
        end else if (clkEn) begin
            sel_r <= sel_nxt;
            flag_r <= flag_nxt;
            boot_r <= boot_nxt;
            bootLoad_r <= bootLoad_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // pointer bank control
    assign pif.sel = sel_r;
    assign pif.op = ptrLoad ? DPS_OP_LOAD : (ptrInc ? DPS_OP_INC : DPS_OP_NONE);
    assign pif.loadVal = ptrLoadVal;

    dps_ptr_bank u_bank (
        .ref_clk(ref_clk),
        .rst(rst),
        .clkEn(clkEn),
        .pb(pif.bank)
    );

    // selector picks the pointer in use
    assign dataPointer = sel_r ? pif.ptrOne : pif.ptrZero;
    // boot window decode of the pointer address
    assign bootWindowHit = boot_r && dataPointer >= DPS_BOOT_LO && dataPointer <= DPS_BOOT_HI;
    assign sfrRdata = rdata_r;
    assign sfrHit = addrHit && (sfrWr || sfrRd || sfrInc);
    assign pointerSelector = sel_r;
    assign bootMapEnable = boot_r;
    assign generalUserFlag = flag_r;

    chk_inc_toggles: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && addrHit && sfrInc && !sfrWr && !bootLoad_r |=> sel_r != $past(sel_r) && flag_r == $past(flag_r)
    ) else $error("increment did not toggle selector alone");
    chk_bit2_zero: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && addrHit && sfrRd |=> sfrRdata[DPS_ZERO_BIT] == 1'b0) else $error("bit 2 read nonzero");
    chk_sel_route: assert property (@(posedge ref_clk) disable iff (rst)
        dataPointer == (pointerSelector ? pif.ptrOne : pif.ptrZero)) else $error("wrong pointer routed");
    chk_flag_write: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && addrHit && sfrWr |=> generalUserFlag == $past(sfrWdata[DPS_FLAG_BIT]))
        else $error("flag not stored");
    chk_boot_window: assert property (@(posedge ref_clk) disable iff (rst)
        bootWindowHit |-> bootMapEnable && dataPointer >= DPS_BOOT_LO) else $error("boot window wrong");
    chk_off_addr: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && !addrHit && !bootLoad_r |=> $stable(sel_r) && $stable(flag_r)) else $error("stray write took");
    chk_reset_sel: assert property (@(posedge ref_clk)
        $past(rst) |-> !pointerSelector) else $error("selector not cleared by reset");
    chk_boot_strap: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && bootLoad_r && !(addrHit && (sfrWr || sfrInc)) |=> boot_r == !$past(bootJumpCfg_n))
        else $error("boot enable not from strap");

    cov_toggle: cover property (@(posedge ref_clk) clkEn && addrHit && sfrInc);
    cov_ptr1_inc: cover property (@(posedge ref_clk) clkEn && sel_r && ptrInc);
    cov_boot_hit: cover property (@(posedge ref_clk) bootWindowHit);
endmodule // dual_pointer_select

// ### verif/dps_core_model.sv
// partner model: core side issuing register and pointer requests
`timescale 1ns/1ns
module dps_core_model
    import dps_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // register requests
    output logic sfrWr,
    output logic sfrRd,
    output logic sfrInc,
    output logic [7:0] sfrAddr,
    output logic [7:0] sfrWdata,
    // pointer requests
    output logic ptrLoad,
    output logic ptrInc,
    output logic [15:0] ptrLoadVal
);
    // idle bus from time zero
    initial begin
        {sfrWr, sfrRd, sfrInc, ptrLoad, ptrInc} = 5'h00;
        sfrAddr = 8'h00;
        sfrWdata = 8'h00;
        ptrLoadVal = 16'h0000;
    end
    // one request a cycle, held until the next call so no signal is set twice at one edge
    task automatic drive(input logic [4:0] strb, input logic [7:0] a, input logic [7:0] d, input logic [15:0] v);
        @(negedge ref_clk);
        {sfrWr, sfrRd, sfrInc, ptrLoad, ptrInc} = strb;
        sfrAddr = a;
        sfrWdata = d & 8'h2d;
        ptrLoadVal = v;
    endtask
endmodule // dps_core_model

// ### verif/dual_pointer_select_tb_top.sv
// testbench: scoreboard run of the dual pointer block, driven by its core model
`timescale 1ns/1ns
module dual_pointer_select_tb_top;
    import dps_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, bootJumpCfg_n = 1'b0, rdSeen = 1'b0;
    logic sfrWr, sfrRd, sfrInc, ptrLoad, ptrInc, sfrHit, pointerSelector, bootMapEnable, generalUserFlag;
    logic bootWindowHit, sel, flag, boot;
    logic [7:0] sfrAddr, sfrWdata, sfrRdata, dm;
    logic [15:0] ptrLoadVal, dataPointer;
    logic [15:0] ptr [2];
    logic [27:0] expQ [$];
    logic [31:0] rng = 32'h00000021;
    int errTotal = 0, nChecks = 0;
    dps_core_model u_dps_core_model (.ref_clk, .sfrWr, .sfrRd, .sfrInc, .sfrAddr, .sfrWdata, .ptrLoad, .ptrInc,
        .ptrLoadVal);
    dual_pointer_select u_dual_pointer_select (.ref_clk, .rst, .clkEn, .bootJumpCfg_n, .sfrWr, .sfrRd, .sfrInc,
        .sfrAddr, .sfrWdata, .sfrRdata, .sfrHit, .ptrLoad, .ptrInc, .ptrLoadVal, .dataPointer, .pointerSelector,
        .bootMapEnable, .generalUserFlag, .bootWindowHit);
    // 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // xorshift source, fixed start
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [7:0] img();
        return {2'h0, boot, 1'h0, flag, 2'h0, sel};
    endfunction
    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected at %0t: seen %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // strobes {wr, rd, inc, load, ptrinc}; expectation follows the edge that takes the request
    task automatic op(input logic [4:0] s, input logic [7:0] a, input logic [7:0] d, input logic [15:0] v);
        logic hitA;
        hitA = (a === DPS_AUX_ADDR);
        dm = d & 8'h2d;
        if (s[3] && hitA) expQ.push_back({img(), ptr[sel], boot && ptr[sel] >= DPS_BOOT_LO, sel, flag, boot});
        u_dps_core_model.drive(s, a, d, v);
        #1;
        check({27'h0000000, sfrHit}, {27'h0000000, hitA && (s[4:2] != 3'h0)});
        // pointer op uses the selector from before the edge
        if (s[1]) ptr[sel] = v;
        else if (s[0]) ptr[sel] = ptr[sel] + DPS_PTR_ONE;
        if (hitA && s[4]) {boot, flag, sel} = {dm[5], dm[3], dm[0]};
        else if (hitA && s[2]) sel = ~sel;
    endtask
    task automatic rd();
        op(5'h08, DPS_AUX_ADDR, 8'h00, 16'h0000);
    endtask
    // idle the strobes first, so a request held from before reset is not taken after release
    task automatic reboot(input logic strap);
        op(5'h00, 8'h00, 8'h00, 16'h0000);
        bootJumpCfg_n = strap;
        rst = 1'b1;
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        {sel, flag, boot} = {1'b0, 1'b0, ~strap};
        ptr[0] = DPS_PTR_RST;
        ptr[1] = DPS_PTR_RST;
        op(5'h00, 8'h00, 8'h00, 16'h0000);
    endtask
    // requests while the enable is low must leave every state untouched
    task automatic frozen();
        u_dps_core_model.drive(5'h07, DPS_AUX_ADDR, 8'h00, 16'h1234);
        clkEn = 1'b0;
        op(5'h00, 8'h00, 8'h00, 16'h0000);
        clkEn = 1'b1;
    endtask
    // monitor: a read taken at an edge shows its result by the next falling edge
    always @(posedge ref_clk) rdSeen <= !rst && sfrRd && sfrAddr == DPS_AUX_ADDR;
    always @(negedge ref_clk) begin
        if (rdSeen) check({sfrRdata, dataPointer, bootWindowHit, pointerSelector, generalUserFlag, bootMapEnable},
            expQ.pop_front());
    end
    // hang guard, far beyond the roughly 640 cycles of the run
    initial begin
        #200000;
        errTotal++;
        conclude();
    end
    initial begin
        logic [31:0] r;
        reboot(1'b0);
        rd();
        op(5'h10, DPS_AUX_ADDR, 8'hff, 16'h0000);
        rd();
        op(5'h02, 8'h00, 8'h00, 16'hffff);
        rd();
        op(5'h01, 8'h00, 8'h00, 16'h0000);
        rd();
        op(5'h04, DPS_AUX_ADDR, 8'h00, 16'h0000);
        rd();
        frozen();
        rd();
        // mixed strobes, stray addresses, pointer ops racing selector changes
        repeat (300) begin
            r = xs();
            op(r[8:4] & 5'h17, r[3] ? DPS_AUX_ADDR : r[15:8], r[23:16], r[31:16]);
            rd();
        end
        reboot(1'b1);
        rd();
        op(5'h00, 8'h00, 8'h00, 16'h0000);
        repeat (2) @(negedge ref_clk);
        conclude();
    end
endmodule // dual_pointer_select_tb_top
